// ==== cgsb_pkg.sv ====
/*
  cgsb_pkg: constants and carrier types for the identification and side-band
  register bank of a clock generator (bytes 8 to 16).
  Assumes: byte-wide register port, 5-bit byte address.
*/
package cgsb_pkg;

  localparam int CGSB_ADDR_W = 5;
  localparam int CGSB_NUM_OUT = 20;
  localparam int CGSB_SHIFT_W = 20;

  // register offsets
  localparam logic [4:0] CGSB_OFS_VENDOR_REVISION_ID = 5'h08;
  localparam logic [4:0] CGSB_OFS_PART_IDENTIFICATION = 5'h09;
  localparam logic [4:0] CGSB_OFS_BLOCK_READ_LENGTH = 5'h0A;
  localparam logic [4:0] CGSB_OFS_SIDEBAND_OVERRIDE_LOW = 5'h0B;
  localparam logic [4:0] CGSB_OFS_SIDEBAND_OVERRIDE_MID = 5'h0C;
  localparam logic [4:0] CGSB_OFS_SIDEBAND_OVERRIDE_HIGH = 5'h0D;
  localparam logic [4:0] CGSB_OFS_SIDEBAND_STATE_LOW = 5'h0E;
  localparam logic [4:0] CGSB_OFS_SIDEBAND_STATE_MID = 5'h0F;
  localparam logic [4:0] CGSB_OFS_SIDEBAND_STATE_HIGH = 5'h10;

  // field layout
  localparam int CGSB_REV_LSB = 4;
  localparam int CGSB_TYPE_LSB = 6;
  localparam logic [7:0] CGSB_LENGTH_MASK = 8'h3F;
  localparam logic [7:0] CGSB_HIGH_MASK = 8'h0F;

  // reset values
  localparam logic [3:0] CGSB_REVISION_RST = 4'h0;
  localparam logic [5:0] CGSB_LENGTH_RST = 6'h08;
  localparam logic [7:0] CGSB_OVERRIDE_RST = 8'h00;
  localparam logic [19:0] CGSB_STATE_RST = 20'hFFFFF;

  // output index map in the 20-bit vectors: 19 clock outputs plus platform time
  localparam int CGSB_IDX_FAST0 = 0;
  localparam int CGSB_IDX_SEL8 = 7;
  localparam int CGSB_IDX_SEL0 = 8;
  localparam int CGSB_IDX_SLOW0 = 16;
  localparam int CGSB_IDX_PFT = 19;
  localparam int CGSB_NUM_FAST = 7;

  typedef enum logic [1:0] {
    CGSB_CLOCK_GENERATOR_TYPE = 2'h0,
    CGSB_ZERO_DELAY_BUFFER_TYPE = 2'h1,
    CGSB_RESERVED_TYPE = 2'h2,
    CGSB_NONZERO_DELAY_BUFFER_TYPE = 2'h3
  } cgsb_dev_type_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [4:0] addr;
    logic [7:0] wdata;
  } cgsb_req_t;

endpackage : cgsb_pkg

// ==== cgsb_regfile.sv ====
/*
  cgsb_regfile: registered byte read mux for the bank.
  Assumes: the bank image is presented flat; one read per request cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module cgsb_regfile
  import cgsb_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic rd_in,
  input wire logic [CGSB_ADDR_W-1:0] addr_in,
  input wire logic [71:0] image_in,
  output logic [7:0] rdata_out,
  output logic rvalid_out
);

  function automatic logic [7:0] pick(input logic [4:0] a, input logic [71:0] img);
    logic [7:0] r;
    r = 8'h00;
    if (a >= CGSB_OFS_VENDOR_REVISION_ID && a <= CGSB_OFS_SIDEBAND_STATE_HIGH) begin
      r = img[8*(32'(a) - 8) +: 8];
    end
    return r;
  endfunction : pick

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_out <= 8'h00;
      rvalid_out <= 1'b0;
    end else begin
      rvalid_out <= rd_in;
      if (rd_in) begin
        rdata_out <= pick(addr_in, image_in);
      end
    end
  end

endmodule : cgsb_regfile
`default_nettype wire

// ==== cgsb_bank.sv ====
/*
  cgsb_bank: identification, block read length, side-band override and
  side-band state registers, plus per-output enable resolution.
  Assumes: register requests come from an SMBus slave on clock_in; the
  side-band load strobe and enable pins are asynchronous and synchronised here.
*/
`timescale 1ns/1ps
`default_nettype none
module cgsb_bank
  import cgsb_pkg::*;
#(
  parameter logic [3:0] VENDOR_CODE = 4'h5,    // arbitrary value
  parameter logic [5:0] PART_CODE = 6'h2A,     // arbitrary value
  parameter logic [1:0] DEVICE_TYPE = CGSB_CLOCK_GENERATOR_TYPE
)(
  input wire logic clock_in,
  input wire logic arst_n_in,
  input wire cgsb_req_t req_in,
  output logic [7:0] rdata_out,
  output logic rvalid_out,
  input wire logic sideband_load_in,
  input wire logic [CGSB_SHIFT_W-1:0] sideband_shift_in,
  input wire logic [CGSB_NUM_OUT-1:0] smbus_enable_in,
  input wire logic [CGSB_NUM_FAST-1:0] fast_enable_n_in,
  output logic [CGSB_NUM_OUT-1:0] output_enable_out,
  output logic [5:0] block_read_length_out
);

  logic rst_s1_q;
  logic rst_n_q;
  logic load_s1_q;
  logic load_s2_q;
  logic load_s3_q;
  logic [CGSB_SHIFT_W-1:0] shift_s1_q;
  logic [CGSB_SHIFT_W-1:0] shift_s2_q;
  logic [CGSB_NUM_FAST-1:0] pin_s1_q;
  logic [CGSB_NUM_FAST-1:0] pin_s2_q;
  logic [3:0] revision_q;
  logic [5:0] length_q;
  logic [CGSB_NUM_OUT-1:0] override_q;
  logic [CGSB_NUM_OUT-1:0] state_q;
  logic [CGSB_NUM_OUT-1:0] enable_d;
  logic [71:0] image;

  // reset release through two flops
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end

  // pin synchronisers
  always_ff @(posedge clock_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      load_s1_q <= 1'b0;
      load_s2_q <= 1'b0;
      load_s3_q <= 1'b0;
      shift_s1_q <= '0;
      shift_s2_q <= '0;
      pin_s1_q <= '1;
      pin_s2_q <= '1;
    end else begin
      load_s1_q <= sideband_load_in;
      load_s2_q <= load_s1_q;
      load_s3_q <= load_s2_q;
      shift_s1_q <= sideband_shift_in;
      shift_s2_q <= shift_s1_q;
      pin_s1_q <= fast_enable_n_in;
      pin_s2_q <= pin_s1_q;
    end
  end

  // revision is constant after power-up
  always_ff @(posedge clock_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      revision_q <= CGSB_REVISION_RST;
    end else begin
      revision_q <= revision_q;
    end
  end

  // writable registers; other addresses and reserved bits drop the write
  always_ff @(posedge clock_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      length_q <= CGSB_LENGTH_RST;
      override_q <= '0;
    end else if (req_in.wr) begin
      case (req_in.addr)
        CGSB_OFS_BLOCK_READ_LENGTH: begin
          length_q <= req_in.wdata[5:0];
        end
        CGSB_OFS_SIDEBAND_OVERRIDE_LOW: begin
          override_q[7:0] <= req_in.wdata;
        end
        CGSB_OFS_SIDEBAND_OVERRIDE_MID: begin
          override_q[15:8] <= req_in.wdata;
        end
        CGSB_OFS_SIDEBAND_OVERRIDE_HIGH: begin
          override_q[19:16] <= req_in.wdata[3:0];
        end
        default: begin
          length_q <= length_q;
        end
      endcase
    end
  end

  // rising edge of the synchronised load latches the shift register
  always_ff @(posedge clock_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q <= CGSB_STATE_RST;
    end else if (load_s2_q && !load_s3_q) begin
      state_q <= shift_s2_q;
    end
  end

  // per-output enable resolution
  always_comb begin
    for (int i = 0; i < CGSB_NUM_OUT; i++) begin
      enable_d[i] = smbus_enable_in[i] && (override_q[i] || state_q[i]);
      if (i < CGSB_NUM_FAST) begin
        enable_d[i] = enable_d[i] && !pin_s2_q[i];
      end
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      output_enable_out <= '0;
      block_read_length_out <= CGSB_LENGTH_RST;
    end else begin
      output_enable_out <= enable_d;
      block_read_length_out <= length_q;
    end
  end

  // flat bank image, byte 8 in the low lane
  assign image = {
    4'h0, state_q[19:16],
    state_q[15:8],
    state_q[7:0],
    4'h0, override_q[19:16],
    override_q[15:8],
    override_q[7:0],
    2'h0, length_q,
    DEVICE_TYPE, PART_CODE,
    revision_q, VENDOR_CODE
  };

  cgsb_regfile u_regfile (
    .clock_in(clock_in),
    .rst_n_in(rst_n_q),
    .rd_in(req_in.rd),
    .addr_in(req_in.addr),
    .image_in(image),
    .rdata_out(rdata_out),
    .rvalid_out(rvalid_out)
  );

endmodule : cgsb_bank
`default_nettype wire

// ==== cgsb_bank_asserts.sv ====
/* cgsb_bank_asserts: port checker for cgsb_bank.
   Assumes one clock, async active-low reset, bound to cgsb_bank. */
`timescale 1ns/1ps
`default_nettype none
module cgsb_bank_asserts
  import cgsb_pkg::*;
#(
  parameter logic [3:0] VENDOR_CODE = 4'h5,
  parameter logic [5:0] PART_CODE = 6'h2A,
  parameter logic [1:0] DEVICE_TYPE = 2'h0
)(
  input wire logic clock_in,
  input wire logic arst_n_in,
  input wire cgsb_req_t req_in,
  input wire logic [7:0] rdata_out,
  input wire logic rvalid_out,
  input wire logic [CGSB_NUM_OUT-1:0] smbus_enable_in,
  input wire logic [CGSB_NUM_OUT-1:0] output_enable_out,
  input wire logic [5:0] block_read_length_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!arst_n_in);
  sequence rd_at(logic [4:0] a); req_in.rd && req_in.addr == a; endsequence
  sequence wr_at(logic [4:0] a); req_in.wr && req_in.addr == a; endsequence
  read_answer_a: assert property (req_in.rd |=> rvalid_out) else $error("read lost");
  valid_cause_a: assert property (rvalid_out |-> $past(req_in.rd)) else $error("stray valid");
  vendor_byte_a: assert property (rd_at(5'h08) |=> rdata_out == {4'h0, VENDOR_CODE})
    else $error("vendor byte");
  part_byte_a: assert property (rd_at(5'h09) |=> rdata_out == {DEVICE_TYPE, PART_CODE})
    else $error("part byte");
  length_write_a: assert property (wr_at(5'h0A) |-> ##2
    block_read_length_out == $past(req_in.wdata[5:0], 2)) else $error("length write");
  length_hold_a: assert property (!req_in.wr |-> ##2 $stable(block_read_length_out))
    else $error("length moved");
  length_rsvd_a: assert property (rd_at(5'h0A) |=> rdata_out[7:6] == 2'h0)
    else $error("length reserved");
  high_rsvd_a: assert property ((rd_at(5'h0D) or rd_at(5'h10)) |=> rdata_out[7:4] == 4'h0)
    else $error("high reserved");
  all_off_a: assert property ((smbus_enable_in == '0) [*3] |=> output_enable_out == '0)
    else $error("enable without bit");
endmodule : cgsb_bank_asserts
bind cgsb_bank cgsb_bank_asserts #(.VENDOR_CODE(VENDOR_CODE), .PART_CODE(PART_CODE),
  .DEVICE_TYPE(DEVICE_TYPE)) u_asserts (.clock_in, .arst_n_in, .req_in, .rdata_out,
  .rvalid_out, .smbus_enable_in, .output_enable_out, .block_read_length_out);
`default_nettype wire

// ==== cgsb_sb_driver.sv ====
/* cgsb_sb_driver: side-band shift/load driver model.
   Assumes the bank synchronises the strobe; shift data held while loading. */
`timescale 1ns/1ps
`default_nettype none
module cgsb_sb_driver (
  input wire logic clock_in,
  output logic load_out,
  output logic [19:0] shift_out
);
  initial begin
    load_out = 1'b0;
    shift_out = 20'h00000;
  end
  task automatic load(input logic [19:0] v);
    shift_out = v;
    @(posedge clock_in) #1;
    load_out = 1'b1;
    repeat (4) @(posedge clock_in) #1;
    load_out = 1'b0;
    // data no longer held after the strobe
    shift_out = ~v;
  endtask : load
endmodule : cgsb_sb_driver
`default_nettype wire

// ==== cgsb_bank_tb_top.sv ====
/* cgsb_bank_tb_top: self-checking bench for cgsb_bank against a bench model.
   Assumes 100 MHz clock, inputs driven 1 ns after the rising edge. */
`timescale 1ns/1ps
`default_nettype none
module cgsb_bank_tb_top import cgsb_pkg::*;;
  localparam logic [3:0] VC = 4'h9; // arbitrary value
  localparam logic [5:0] PC = 6'h15; // arbitrary value
  logic clock_in = 0, arst_n = 0;
  cgsb_req_t req = '0;
  logic [19:0] se = '0, ovr = '0, st = 20'hFFFFF, v, e;
  logic [6:0] pin = '1;
  logic [5:0] len = 6'h08;
  wire logic [7:0] rdata;
  wire logic rvalid, load;
  wire logic [19:0] shift, oe;
  wire logic [5:0] blen;
  int fail_count = 0, n_checks = 0;
  always #5 clock_in = ~clock_in;
  cgsb_sb_driver u_cgsb_sb_driver (.clock_in(clock_in), .load_out(load), .shift_out(shift));
  cgsb_bank #(.VENDOR_CODE(VC), .PART_CODE(PC)) u_cgsb_bank (.clock_in(clock_in),
    .arst_n_in(arst_n), .req_in(req), .rdata_out(rdata), .rvalid_out(rvalid),
    .sideband_load_in(load), .sideband_shift_in(shift), .smbus_enable_in(se),
    .fast_enable_n_in(pin), .output_enable_out(oe), .block_read_length_out(blen));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  function automatic logic [7:0] exp_b(input logic [4:0] a);
    case (a)
      5'h08: return {4'h0, VC};
      5'h09: return {2'h0, PC};
      5'h0A: return {2'h0, len};
      5'h0B: return ovr[7:0];
      5'h0C: return ovr[15:8];
      5'h0D: return {4'h0, ovr[19:16]};
      5'h0E: return st[7:0];
      5'h0F: return st[15:8];
      5'h10: return {4'h0, st[19:16]};
      default: return 8'h00;
    endcase
  endfunction : exp_b
  task automatic op(input logic w, input logic [4:0] a, input logic [7:0] d);
    req = '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge clock_in) #1;
    req = '0;
    if (!w) begin
      chk(rvalid, 1);
      chk(rdata, exp_b(a));
    end else if (a == 5'h0A) len = d[5:0];
    else if (a == 5'h0B) ovr[7:0] = d;
    else if (a == 5'h0C) ovr[15:8] = d;
    else if (a == 5'h0D) ovr[19:16] = d[3:0];
    @(posedge clock_in) #1;
  endtask : op
  task automatic read_all;
    for (int a = 0; a < 32; a++) op(1'b0, a[4:0], 8'h00);
    chk(blen, len);
  endtask : read_all
  task automatic give_verdict;
    $display("checks=%0d errors=%0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : give_verdict
  initial begin
    #200000;
    fail_count++;
    give_verdict();
  end
  initial begin
    void'($urandom(32'h285B));
    repeat (20) @(posedge clock_in);
    #1 arst_n = 1;
    repeat (3) @(posedge clock_in) #1;
    read_all();
    repeat (12) begin
      for (int a = 8; a <= 16; a++) op(1'b1, a[4:0], 8'($urandom));
      se = 20'($urandom);
      pin = 7'($urandom);
      v = 20'($urandom);
      u_cgsb_sb_driver.load(v);
      st = v;
      read_all();
      for (int i = 0; i < 20; i++) e[i] = se[i] & (ovr[i] | st[i]) & (i >= 7 || !pin[i]);
      chk(oe, e);
    end
    give_verdict();
  end
endmodule : cgsb_bank_tb_top
`default_nettype wire
